// file: hw/dlc_top.sv
// one dma channel's link, modulo and request-disable control with apb registers
// How it works
// [RL1] dest modulo zero off, else 16B shl
// [RL2] disable-request bit clears ext enable at zero
// [RL3] link condition pulses request to target channel
// [RL4] link field decodes none/both/steal/zero
// [RL5] continuous mode gives no first link; code 11 still links to the first target at zero
// [RL6] code 01 switches to second at zero
// [RL7] linking forces bandwidth limit to zero
// [RL8] first target from bits 3-2
// [RL9] second target from bits 1-0
// [RL10] target equal own channel sets config error
// [RL11] ext enable gates external requests
// [RL12] steal one transfer, continuous until limit
// [RL13] link request is one-cycle pulse
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "dlc_map.svh"
module dlc_top
	import dlc_pkg::*;
#(
	parameter int         NCH     = 4,
	parameter logic [1:0] OWN_CH  = 2'h0
) (
	// clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	// channel side
	input  wire logic            ext_req,
	input  wire logic            int_start,
	input  wire logic            xfer_done,
	input  wire logic [3:0]      xfer_bytes,
	input  wire logic            bw_boundary,
	// outputs to channel and partners
	output logic                 xfer_req,
	output logic [NCH-1:0]       link_req,
	output logic [2:0]           bandwidth_eff,
	output logic [17:0]          dest_wrap_mask,
	output logic                 irq
);
	logic [31:0] ctrl_r;
	logic [23:0] byte_count_r;
	logic        cfg_err_r;
	logic [3:0]  irq_stat_r;
	logic [3:0]  irq_mask_r;
	logic        busy_r;
	logic        pending_r;
	logic        wr_en;
	logic        rd_en;
	logic        count_zero;
	logic        steal_done;
	logic        link1_fire;
	logic        link2_fire;
	logic        cfg_bad;
	logic [3:0]  irq_set;
	logic [23:0] count_nxt;
	logic        cs;
	logic        ext_en;
	logic        ext_seen;

	// apb: zero wait state, every access completes in its access phase
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;

	// decoding for the error answer; the read mux decodes with its own case
	function automatic logic addr_known(input logic [11:0] a);
		return a == `DLC_OFF_CTRL || a == `DLC_OFF_STATUS || a == `DLC_OFF_BCOUNT
		    || a == `DLC_OFF_IRQ_STAT || a == `DLC_OFF_IRQ_MASK || a == `DLC_OFF_EVENT;
	endfunction : addr_known

	assign pslverr = psel && penable && !addr_known(paddr);

	assign cs     = ctrl_r[`DLC_CTRL_CS];
	assign ext_en = ctrl_r[`DLC_CTRL_EXT_EN];

	// count hits zero on the transfer that exhausts it
	always_comb begin
		count_nxt = byte_count_r;
		if (xfer_done && busy_r)
			count_nxt = (byte_count_r > 24'(xfer_bytes)) ? byte_count_r - 24'(xfer_bytes)
			                                              : 24'h00_0000;
	end
	assign count_zero = xfer_done && busy_r && (count_nxt == 24'h00_0000);
	assign steal_done = xfer_done && busy_r;

	// external request only counts while enabled
	assign ext_seen = ext_req && ext_en; // RL11

	// control register, with hardware clear of ext enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `DLC_CTRL_RESET;
		end else begin
			if (wr_en && paddr == `DLC_OFF_CTRL)
				ctrl_r <= pwdata & `DLC_CTRL_WMASK;
			// hardware clear wins over a write in the same cycle
			if (count_zero && ctrl_r[`DLC_CTRL_DREQ])
				ctrl_r[`DLC_CTRL_EXT_EN] <= 1'b0; // RL2
		end
	end

	// byte count, software loaded, decremented per completed transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			byte_count_r <= `DLC_BCOUNT_RESET;
		else if (wr_en && paddr == `DLC_OFF_BCOUNT)
			byte_count_r <= pwdata[23:0];
		else
			byte_count_r <= count_nxt;
	end

	// channel activity: steal does one transfer, continuous runs on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r    <= 1'b0;
			pending_r <= 1'b0;
		end else begin
			if ((int_start || ext_seen) && byte_count_r != 24'h00_0000)
				busy_r <= 1'b1;
			else if (count_zero)
				busy_r <= 1'b0;
			else if (steal_done && cs)
				busy_r <= 1'b0; // RL12
			pending_r <= busy_r && !(steal_done && (cs || count_zero));
		end
	end

	// continuous mode drops xfer_req for every cycle bw_boundary is high while the bandwidth is nonzero
	assign xfer_req = busy_r && !(bw_boundary && bandwidth_eff != 3'h0
	                              && !cs); // RL12

	// bandwidth value seen by the arbiter
	assign bandwidth_eff = (ctrl_r[`DLC_CTRL_LINK_HI:`DLC_CTRL_LINK_LO] != 2'h0) ? 3'h0
	                      : ctrl_r[`DLC_CTRL_BW_HI:`DLC_CTRL_BW_LO]; // RL7

	// destination wrap mask: zero means no wrap, code n gives 2^(n+3) bytes
	always_comb begin
		logic [3:0] m;
		m = ctrl_r[`DLC_CTRL_DSTMOD_HI:`DLC_CTRL_DSTMOD_LO];
		dest_wrap_mask = 18'h0_0000;
		if (m != 4'h0)
			dest_wrap_mask = 18'((19'h1 << (5'(m) + 5'(`DLC_MOD_BASE_SHIFT))) - 19'h1); // RL1
	end

	dlc_link_decode #(
		.NCH(NCH)
	) u_link (
		.pclk               (pclk),
		.presetn            (presetn),
		.link_control       (ctrl_r[`DLC_CTRL_LINK_HI:`DLC_CTRL_LINK_LO]),
		.first_link_target  (ctrl_r[`DLC_CTRL_T1_HI:`DLC_CTRL_T1_LO]),
		.second_link_target (ctrl_r[`DLC_CTRL_T2_HI:`DLC_CTRL_T2_LO]),
		.cycle_steal        (cs),
		.steal_done         (steal_done),
		.count_zero         (count_zero),
		.link_req           (link_req),
		.link1_fire         (link1_fire),
		.link2_fire         (link2_fire)
	);

	// a link target naming this channel is a configuration error
	assign cfg_bad = ctrl_r[`DLC_CTRL_LINK_HI:`DLC_CTRL_LINK_LO] != 2'h0
	              && (ctrl_r[`DLC_CTRL_T1_HI:`DLC_CTRL_T1_LO] == OWN_CH
	               || ctrl_r[`DLC_CTRL_T2_HI:`DLC_CTRL_T2_LO] == OWN_CH); // RL10

	// status error flag: set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_err_r <= 1'b0;
		else if (cfg_bad)
			cfg_err_r <= 1'b1; // RL10
		else if (wr_en && paddr == `DLC_OFF_STATUS && pwdata[0])
			cfg_err_r <= 1'b0;
	end

	// interrupt events
	always_comb begin
		irq_set = 4'h0;
		irq_set[`DLC_IRQ_LINK1]   = link1_fire;
		irq_set[`DLC_IRQ_LINK2]   = link2_fire;
		irq_set[`DLC_IRQ_CFGERR]  = cfg_bad && !cfg_err_r;
		irq_set[`DLC_IRQ_EXHAUST] = count_zero;
	end

	// sticky status, write one to clear, a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat_r <= 4'h0;
		else if (wr_en && paddr == `DLC_OFF_IRQ_STAT)
			irq_stat_r <= (irq_stat_r & ~pwdata[3:0]) | irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end

	// interrupt mask, one enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask_r <= 4'h0;
		else if (wr_en && paddr == `DLC_OFF_IRQ_MASK)
			irq_mask_r <= pwdata[3:0];
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// read data registered in the setup phase, held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`DLC_OFF_CTRL:     prdata <= ctrl_r;
				`DLC_OFF_STATUS:   prdata <= {29'h0, pending_r, busy_r, cfg_err_r};
				`DLC_OFF_BCOUNT:   prdata <= {8'h00, byte_count_r};
				`DLC_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat_r};
				`DLC_OFF_IRQ_MASK: prdata <= {28'h0, irq_mask_r};
				`DLC_OFF_EVENT:    prdata <= {30'h0, count_zero, steal_done};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

	logic unused_rd;
	assign unused_rd = rd_en;
endmodule : dlc_top

// file: shared/dlc_map.svh
// register offsets, field positions, reset values and the modulo base shift for the link control block
`ifndef DLC_MAP_SVH
`define DLC_MAP_SVH

`define DLC_OFF_CTRL        12'h000
`define DLC_OFF_STATUS      12'h004
`define DLC_OFF_BCOUNT      12'h008
`define DLC_OFF_IRQ_STAT    12'h00c
`define DLC_OFF_IRQ_MASK    12'h010
`define DLC_OFF_EVENT       12'h014

`define DLC_CTRL_CS         31
`define DLC_CTRL_EXT_EN     30
`define DLC_CTRL_BW_HI      27
`define DLC_CTRL_BW_LO      25
`define DLC_CTRL_DSTMOD_HI  11
`define DLC_CTRL_DSTMOD_LO  8
`define DLC_CTRL_DREQ       7
`define DLC_CTRL_LINK_HI    5
`define DLC_CTRL_LINK_LO    4
`define DLC_CTRL_T1_HI      3
`define DLC_CTRL_T1_LO      2
`define DLC_CTRL_T2_HI      1
`define DLC_CTRL_T2_LO      0
`define DLC_CTRL_WMASK      32'hce00_0fbf

`define DLC_EV_STEAL        0
`define DLC_EV_EXHAUST      1

`define DLC_IRQ_LINK1       0
`define DLC_IRQ_LINK2       1
`define DLC_IRQ_CFGERR      2
`define DLC_IRQ_EXHAUST     3

`define DLC_CTRL_RESET      32'h0000_0000
`define DLC_BCOUNT_RESET    24'h00_0000
`define DLC_MOD_BASE_SHIFT  4'h3

`endif

// file: shared/dlc_pkg.sv
// types shared by the link control block
package dlc_pkg;
	typedef enum logic [1:0] {
		DLC_LINK_NONE   = 2'h0,
		DLC_LINK_BOTH   = 2'h1,
		DLC_LINK_STEAL  = 2'h2,
		DLC_LINK_ZERO   = 2'h3
	} dlc_link_t;

	typedef enum logic [2:0] {
		DLC_ST_IDLE  = 3'h1,
		DLC_ST_SETUP = 3'h2,
		DLC_ST_ACC   = 3'h4
	} dlc_apb_st_t;
endpackage : dlc_pkg

// file: hw/dlc_link_decode.sv
// decode of link condition into one-shot requests towards the target channels
`timescale 1ns/1ps
`include "dlc_map.svh"
module dlc_link_decode
	import dlc_pkg::*;
#(
	parameter int NCH = 4
) (
	// clock and reset
	input  wire logic           pclk,
	input  wire logic           presetn,
	// configuration
	input  wire logic [1:0]     link_control,
	input  wire logic [1:0]     first_link_target,
	input  wire logic [1:0]     second_link_target,
	input  wire logic           cycle_steal,
	// channel events
	input  wire logic           steal_done,
	input  wire logic           count_zero,
	// request pulses
	output logic [NCH-1:0]      link_req,
	output logic                link1_fire,
	output logic                link2_fire
);
	logic l1;
	logic l2;
	logic [NCH-1:0] req_nxt;

	// which link condition applies this cycle
	always_comb begin
		l1 = 1'b0;
		l2 = 1'b0;
		case (dlc_link_t'(link_control))
			DLC_LINK_BOTH: begin
				l1 = cycle_steal && steal_done && !count_zero; // RL6 RL5
				l2 = count_zero; // RL6
			end
			DLC_LINK_STEAL: begin
				l1 = cycle_steal && steal_done; // RL5
			end
			DLC_LINK_ZERO: begin
				l1 = count_zero;
			end
			default: begin
				l1 = 1'b0; // RL4
			end
		endcase
	end

	// one-hot target select per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_tgt
			assign req_nxt[g] = (l1 && first_link_target == 2'(g))   // RL8 RL3
			                 || (l2 && second_link_target == 2'(g)); // RL9
		end
	endgenerate

	// registered single-cycle pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_req   <= '0;
			link1_fire <= 1'b0;
			link2_fire <= 1'b0;
		end else begin
			link_req   <= req_nxt; // RL13
			link1_fire <= l1;
			link2_fire <= l2;
		end
	end
endmodule : dlc_link_decode

// file: bench/dlc_top_asserts.sv
// port-level checks for the link control block
`timescale 1ns/1ps
`include "dlc_map.svh"
module dlc_top_asserts
	import dlc_pkg::*;
#(
	parameter int NCH = 4
) (
	// clock and reset
	input wire logic           pclk,
	input wire logic           presetn,
	// apb
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [11:0]    paddr,
	input wire logic [31:0]    pwdata,
	input wire logic           pslverr,
	// channel
	input wire logic           xfer_done,
	input wire logic [NCH-1:0] link_req,
	input wire logic [2:0]     bandwidth_eff,
	input wire logic [17:0]    dest_wrap_mask
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] ctl_r;
	// shadow of written fields; hardware only touches bit 30, unused here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl_r <= 32'h0;
		else if (psel && penable && pwrite && paddr == `DLC_OFF_CTRL)
			ctl_r <= pwdata & `DLC_CTRL_WMASK;
	end
	sequence s_steal;
		xfer_done && ctl_r[31] && ctl_r[5:4] == 2'h2;
	endsequence
	sequence s_cont;
		xfer_done && !ctl_r[31] && ctl_r[5:4] == 2'h2;
	endsequence
	chk_bw_forced: assert property (ctl_r[5:4] != 2'h0 |-> bandwidth_eff == 3'h0)
		else $error("bandwidth not forced");
	chk_bw_pass: assert property (ctl_r[5:4] == 2'h0 |-> bandwidth_eff == ctl_r[27:25])
		else $error("bandwidth not passed");
	chk_wrap_mask: assert property (dest_wrap_mask == (ctl_r[11:8] == 4'h0 ? 18'h0 :
		18'((19'h1 << (5'(ctl_r[11:8]) + 5'h3)) - 19'h1)))
		else $error("wrap mask wrong");
	chk_steal_first: assert property (s_steal |=>
		$onehot(link_req) && link_req[$past(ctl_r[3:2])])
		else $error("first link missing");
	chk_cont_none: assert property (s_cont |=> link_req == '0)
		else $error("link in continuous mode");
	chk_link_cause: assert property (link_req != '0 |-> $past(xfer_done))
		else $error("link without transfer");
	chk_one_target: assert property ($onehot0(link_req))
		else $error("several links at once");
	chk_bad_addr: assert property (psel && penable |->
		pslverr == (paddr > `DLC_OFF_EVENT || paddr[1:0] != 2'h0))
		else $error("slave error wrong");
endmodule : dlc_top_asserts

bind dlc_top dlc_top_asserts #(.NCH(NCH)) dlc_top_asserts_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.xfer_done(xfer_done), .link_req(link_req), .bandwidth_eff(bandwidth_eff),
	.dest_wrap_mask(dest_wrap_mask));

// file: bench/dlc_peer_model.sv
// far-side channels taking link pulses as start requests
`timescale 1ns/1ps
module dlc_peer_model
	import dlc_pkg::*;
#(
	parameter int NCH = 4
) (
	// clock and reset
	input wire logic           pclk,
	input wire logic           presetn,
	// link pulses in
	input wire logic [NCH-1:0] link_req,
	// starts taken so far
	output logic [15:0]        start_cnt
);
	// a pulse held two cycles would count twice, exposing a stretched pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			start_cnt <= 16'h0;
		else
			start_cnt <= start_cnt + 16'($countones(link_req));
	end
endmodule : dlc_peer_model

// file: bench/dlc_top_test.sv
// self-checking bench for the link control block
`timescale 1ns/1ps
`include "dlc_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dlc_top_test
	import dlc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        ext_req, int_start, xfer_done, xfer_req, irq, bw_boundary;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, ctl, me, ee;
	logic [3:0]  xfer_bytes, link_req, e4;
	logic [1:0]  t1, t2;
	logic [2:0]  bandwidth_eff;
	logic [17:0] dest_wrap_mask;
	logic [15:0] start_cnt;
	logic [31:0] rq[$], mq[$];
	logic [3:0]  lq[$];
	int          error_cnt, num_checks, cyc, nlk;
	always #20 pclk = ~pclk;
	dlc_top #(.NCH(4), .OWN_CH(2'h0)) dlc_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_req(ext_req),
		.int_start(int_start), .xfer_done(xfer_done), .xfer_bytes(xfer_bytes),
		.bw_boundary(bw_boundary), .xfer_req(xfer_req), .link_req(link_req),
		.bandwidth_eff(bandwidth_eff), .dest_wrap_mask(dest_wrap_mask), .irq(irq));
	dlc_peer_model #(.NCH(4)) dlc_peer_model_inst (.pclk(pclk), .presetn(presetn),
		.link_req(link_req), .start_cnt(start_cnt));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// entered just after a rising edge, leaves just after one
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		rq.push_back(e);
		mq.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// note the pulses a transfer should cause, then report it
	task automatic xf(input logic fin, input logic [1:0] c, input logic cs);
		if ((c == 2'h2 && cs) || (c == 2'h1 && cs && !fin) || (c == 2'h3 && fin)) begin
			lq.push_back(4'h1 << t1);
			nlk++;
		end
		if (c == 2'h1 && fin) begin
			lq.push_back(4'h1 << t2);
			nlk++;
		end
		// steal mode goes idle after each transfer, so every transfer gets its own start
		int_start <= 1'b1;
		@(posedge pclk);
		int_start <= 1'b0;
		xfer_done <= 1'b1;
		xfer_bytes <= 4'h4;
		@(posedge pclk);
		xfer_done <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : xf
	task automatic results();
		if (lq.size() != 0)
			error_cnt++;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	// results as they appear, against the oldest note
	always @(posedge pclk) begin
		if (presetn && psel && penable && !pwrite && pready) begin
			me = mq.pop_front();
			ee = rq.pop_front();
			`CHK(prdata & me, ee)
		end
		if (presetn && link_req !== 4'h0) begin
			e4 = lq.size() ? lq.pop_front() : 4'hx;
			`CHK(link_req, e4)
		end
	end
	// hang guard, far above the real run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, ext_req, int_start, xfer_done, bw_boundary} = '0;
		{paddr, pwdata, xfer_bytes, error_cnt, num_checks, cyc, nlk} = '0;
		r = 32'ha7de;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// all words clear after reset; 0x18 is unmapped and reads zero
		for (int a = 0; a <= 24; a += 4)
			rd(12'(a), 32'h0, 32'hffff_ffff);
		$display("test reset done");
		// every link code in both modes, random targets, modulo, bandwidth
		for (int k = 0; k < 8; k++) begin
			r = lfsr(r);
			t1 = 2'(r[1:0] % 3) + 2'h1;
			t2 = 2'(r[3:2] % 3) + 2'h1;
			ctl = (r & 32'h0e00_0f00) | (32'(k[0]) << 31) | 32'h4000_0000;
			ctl = ctl | (32'(r[4]) << 7) | (32'(k[2:1]) << 4) | {28'h0, t1, t2};
			apb(1'b1, `DLC_OFF_BCOUNT, 32'h8);
			apb(1'b1, `DLC_OFF_CTRL, ctl);
			xf(1'b0, k[2:1], k[0]);
			xf(1'b1, k[2:1], k[0]);
			rd(`DLC_OFF_CTRL, r[4] ? ctl & 32'hbfff_ffff : ctl, 32'hffff_ffff);
		end
		$display("test links done");
		// continuous mode holds off at a boundary, unless linking forces zero bandwidth
		apb(1'b1, `DLC_OFF_BCOUNT, 32'h4);
		apb(1'b1, `DLC_OFF_CTRL, 32'h0200_0000);
		int_start <= 1'b1;
		bw_boundary <= 1'b1;
		@(posedge pclk);
		int_start <= 1'b0;
		@(negedge pclk);
		`CHK(xfer_req, 1'b0)
		@(posedge pclk);
		apb(1'b1, `DLC_OFF_CTRL, 32'h0200_0025);
		@(negedge pclk);
		`CHK(xfer_req, 1'b1)
		@(posedge pclk);
		bw_boundary <= 1'b0;
		xfer_done <= 1'b1;
		@(posedge pclk);
		xfer_done <= 1'b0;
		@(negedge pclk);
		`CHK(xfer_req, 1'b0)
		@(posedge pclk);
		$display("test bandwidth done");
		// external request honoured only while enabled; a running steal still ends
		apb(1'b1, `DLC_OFF_BCOUNT, 32'h8);
		apb(1'b1, `DLC_OFF_CTRL, 32'hc000_0000);
		ext_req <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		`CHK(xfer_req, 1'b1)
		@(posedge pclk);
		apb(1'b1, `DLC_OFF_CTRL, 32'h8000_0000);
		xfer_done <= 1'b1;
		@(posedge pclk);
		xfer_done <= 1'b0;
		@(negedge pclk);
		`CHK(xfer_req, 1'b0)
		@(posedge pclk);
		ext_req <= 1'b0;
		$display("test ext done");
		// both targets name this channel: error flag, masked then seen
		apb(1'b1, `DLC_OFF_IRQ_STAT, 32'hf);
		apb(1'b1, `DLC_OFF_CTRL, 32'h0000_0010);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		@(posedge pclk);
		apb(1'b1, `DLC_OFF_IRQ_MASK, 32'h4);
		@(negedge pclk);
		`CHK(irq, 1'b1)
		@(posedge pclk);
		rd(`DLC_OFF_STATUS, 32'h1, 32'h1);
		apb(1'b1, `DLC_OFF_CTRL, 32'h0);
		apb(1'b1, `DLC_OFF_STATUS, 32'h1);
		apb(1'b1, `DLC_OFF_IRQ_STAT, 32'h4);
		rd(`DLC_OFF_STATUS, 32'h0, 32'h1);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		`CHK(start_cnt, 16'(nlk))
		$display("test cfgerr done");
		results();
	end
endmodule : dlc_top_test
